// [opc_regs.vh]
// Register map, field layout, strap settings and timing constants of the clock control block.
`ifndef OPC_REGS_VH
`define OPC_REGS_VH

`define OPC_ADDR_W        8
`define OPC_ADDR_PLL      8'h00
`define OPC_ADDR_STAT     8'h04
`define OPC_ADDR_REF      8'h08
`define OPC_ADDR_TIMER    8'h0c
`define OPC_ADDR_CLKBLK   8'h10
`define OPC_ADDR_TILE     8'h14

`define OPC_RESP_OKAY     2'h0
`define OPC_RESP_SLVERR   2'h2

`define OPC_PLL_R_LSB     0
`define OPC_PLL_F_LSB     8
`define OPC_PLL_OD_LSB    24
`define OPC_STAT_DONE     0
`define OPC_STAT_STRAP    1
`define OPC_STAT_SRC      3
`define OPC_STAT_RATIO    16
`define OPC_CB_SRC        0
`define OPC_CB_OE         1
`define OPC_CB_DIV        8
`define OPC_CB_PORT       16

`define OPC_S00_OD        3'h1
`define OPC_S00_F         12'h07a
`define OPC_S11_F         12'h077
`define OPC_S10_F         12'h031
`define OPC_S01_F         12'h017
`define OPC_SXX_OD        3'h2
`define OPC_S_R           6'h00

`define OPC_RATIO_S00     16'h0c03
`define OPC_RATIO_S11     16'h07d0
`define OPC_RATIO_S10     16'h0341
`define OPC_RATIO_S01     16'h0190

`define OPC_CLK_HZ        125000000
`define OPC_CLK_MHZ       125
`define OPC_SLOW_HZ       31250
`define OPC_INT_OSC_KHZ   20000
`define OPC_REF_MHZ_RST   8'h64
`define OPC_BOOT_WAIT     750000
`define OPC_STRAP_EDGE    2'h3

`endif

// [opc_clock_ctrl.v]
// Oscillator select, PLL configuration, reference clock, timer and clock block control.
`timescale 1ns/1ns
`default_nettype none
`include "opc_regs.vh"

module opc_clock_ctrl #(
  parameter BOOT_WAIT   = `OPC_BOOT_WAIT,
  parameter EXT_OSC_KHZ = 12000
) (
  // Clock and reset.
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite register slave.
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Board straps.
  input  wire        clk_source_select_n,
  input  wire        pll_strap_lo,
  input  wire        pll_strap_hi,
  // PLL and oscillator control.
  output reg  [2:0]  post_divider,
  output reg  [11:0] pll_multiplier,
  output reg  [5:0]  pll_input_divider,
  output reg         int_osc_select,
  output reg         analog_clk_int_osc,
  output reg         pll_clk_enable,
  // Boot sequencing.
  output reg         pull_enable,
  output reg         boot_start,
  // Slow oscillator tick and reference tick.
  output reg         slow_tick,
  output reg         ref_tick,
  // Clock block 0.
  input  wire        cb_ext_clk_pin,
  output reg         cb_pin_out,
  output reg         cb_pin_oe,
  output reg         cb_tick,
  output reg  [7:0]  port_clkblk_sel
);

  localparam integer SLOW_CYC  = `OPC_CLK_HZ / `OPC_SLOW_HZ;
  localparam integer SLOW_END  = SLOW_CYC - 1;
  localparam integer BOOT_END  = BOOT_WAIT - 1;
  localparam integer CLK_MHZ_I = `OPC_CLK_MHZ;
  localparam [11:0]  SLOW_LAST = SLOW_END[11:0];
  localparam [19:0]  BOOT_LAST = BOOT_END[19:0];
  localparam [7:0]   CLK_MHZ   = CLK_MHZ_I[7:0];

  // Boot sequence states.
  localparam [3:0] ST_RESET = 4'h1;
  localparam [3:0] ST_WAIT  = 4'h2;
  localparam [3:0] ST_BOOT  = 4'h4;
  localparam [3:0] ST_RUN   = 4'h8;

  function [31:0] apply_strb;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        apply_strb[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
      end
    end
  endfunction

  // Tile frequency in kHz for the given oscillator and PLL settings.
  function [31:0] tile_khz;
    input [31:0] osc_khz;
    input [11:0] f_v;
    input [5:0]  r_v;
    input [2:0]  od_v;
    reg   [47:0] num;
    reg   [15:0] den;
    reg   [47:0] quo;
    begin
      num = osc_khz * ({36'h0, f_v} + 48'h1);
      den = 16'h2 * ({10'h0, r_v} + 16'h1) * ({13'h0, od_v} + 16'h1);
      quo = num / {32'h0, den};
      tile_khz = quo[31:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and strap capture.

  reg [1:0] src_sync_q;
  reg [1:0] lo_sync_q;
  reg [1:0] hi_sync_q;
  reg [2:0] ext_sync_q;
  reg [1:0] edge_cnt_q;
  reg [1:0] strap_q;
  reg [3:0] state_q;
  reg [19:0] boot_cnt_q;
  reg [15:0] ratio_q;
  wire strap_capture = (edge_cnt_q == `OPC_STRAP_EDGE - 2'h1);

  always @(posedge aclk) begin
    if (!aresetn) begin
      src_sync_q <= 2'h0;
      lo_sync_q  <= 2'h0;
      hi_sync_q  <= 2'h0;
      ext_sync_q <= 3'h0;
    end else begin
      src_sync_q <= {src_sync_q[0], clk_source_select_n};
      lo_sync_q  <= {lo_sync_q[0], pll_strap_lo};
      hi_sync_q  <= {hi_sync_q[0], pll_strap_hi};
      ext_sync_q <= {ext_sync_q[1:0], cb_ext_clk_pin};
    end
  end

  // Straps and source select are caught on the third edge after release.
  always @(posedge aclk) begin
    if (!aresetn) begin
      edge_cnt_q         <= 2'h0;
      strap_q            <= 2'h0;
      int_osc_select     <= 1'b0;
      analog_clk_int_osc <= 1'b0;
    end else if (state_q == ST_RESET) begin
      edge_cnt_q <= edge_cnt_q + 2'h1;
      if (strap_capture) begin
        strap_q            <= {hi_sync_q[1], lo_sync_q[1]};
        int_osc_select     <= src_sync_q[1];
        analog_clk_int_osc <= src_sync_q[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot sequencer.

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q        <= ST_RESET;
      boot_cnt_q     <= 20'h0;
      pull_enable    <= 1'b0;
      boot_start     <= 1'b0;
      pll_clk_enable <= 1'b0;
    end else begin
      boot_start <= 1'b0;
      case (state_q)
        ST_RESET: begin
          if (strap_capture) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          boot_cnt_q <= boot_cnt_q + 20'h1;
          if (boot_cnt_q == BOOT_LAST) begin
            state_q <= ST_BOOT;
          end
        end
        ST_BOOT: begin
          pull_enable    <= 1'b1;
          boot_start     <= 1'b1;
          pll_clk_enable <= 1'b1;
          state_q        <= ST_RUN;
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  reg        aw_full_q;
  reg [7:0]  aw_addr_q;
  reg        w_full_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  reg [7:0]  ref_mhz_q;
  reg [7:0]  cb_div_q;
  reg        cb_src_ext_q;
  reg [31:0] timer_q;
  wire       wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
  wire [31:0] pll_word = {5'h0, post_divider, 4'h0, pll_multiplier, 2'h0, pll_input_divider};
  wire [31:0] ref_word = {24'h0, ref_mhz_q};
  wire [31:0] cb_word  = {8'h0, port_clkblk_sel, cb_div_q, 6'h0, cb_pin_oe, cb_src_ext_q};
  wire [31:0] osc_khz  = int_osc_select ? `OPC_INT_OSC_KHZ : EXT_OSC_KHZ;
  wire [31:0] wr_pll   = apply_strb(pll_word, w_data_q, w_strb_q);
  wire [31:0] wr_ref   = apply_strb(ref_word, w_data_q, w_strb_q);
  wire [31:0] wr_cb    = apply_strb(cb_word, w_data_q, w_strb_q);

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  assign s_axi_arready = !s_axi_rvalid;

  // Boot PLL ratio for the captured straps, shown in hundredths.
  always @* begin
    case (strap_q)
      2'b00:   ratio_q = `OPC_RATIO_S00;
      2'b11:   ratio_q = `OPC_RATIO_S11;
      2'b10:   ratio_q = `OPC_RATIO_S10;
      default: ratio_q = `OPC_RATIO_S01;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q    <= 1'b0;
      aw_addr_q    <= 8'h0;
      w_full_q     <= 1'b0;
      w_data_q     <= 32'h0;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OPC_RESP_OKAY;
      post_divider      <= `OPC_S00_OD;
      pll_multiplier    <= `OPC_S00_F;
      pll_input_divider <= `OPC_S_R;
      ref_mhz_q    <= `OPC_REF_MHZ_RST;
      cb_src_ext_q <= 1'b0;
      cb_pin_oe    <= 1'b0;
      cb_div_q     <= 8'h0;
      port_clkblk_sel <= 8'h0;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Strap decoding reloads the PLL fields once; software owns them after.
      if (strap_capture && state_q == ST_RESET) begin
        pll_input_divider <= `OPC_S_R;
        case ({hi_sync_q[1], lo_sync_q[1]})
          2'b00: begin
            post_divider   <= `OPC_S00_OD;
            pll_multiplier <= `OPC_S00_F;
          end
          2'b11: begin
            post_divider   <= `OPC_SXX_OD;
            pll_multiplier <= `OPC_S11_F;
          end
          2'b10: begin
            post_divider   <= `OPC_SXX_OD;
            pll_multiplier <= `OPC_S10_F;
          end
          default: begin
            post_divider   <= `OPC_SXX_OD;
            pll_multiplier <= `OPC_S01_F;
          end
        endcase
      end else if (wr_go) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `OPC_RESP_OKAY;
        if (aw_addr_q == `OPC_ADDR_PLL) begin
          // Range limits are left to software; values are taken as written.
          post_divider      <= wr_pll[`OPC_PLL_OD_LSB +: 3];
          pll_multiplier    <= wr_pll[`OPC_PLL_F_LSB +: 12];
          pll_input_divider <= wr_pll[`OPC_PLL_R_LSB +: 6];
        end else if (aw_addr_q == `OPC_ADDR_REF) begin
          ref_mhz_q <= wr_ref[7:0];
        end else if (aw_addr_q == `OPC_ADDR_CLKBLK) begin
          cb_src_ext_q    <= wr_cb[`OPC_CB_SRC];
          cb_pin_oe       <= wr_cb[`OPC_CB_OE];
          cb_div_q        <= wr_cb[`OPC_CB_DIV +: 8];
          port_clkblk_sel <= wr_cb[`OPC_CB_PORT +: 8];
        end else if (aw_addr_q == `OPC_ADDR_STAT || aw_addr_q == `OPC_ADDR_TIMER ||
                     aw_addr_q == `OPC_ADDR_TILE) begin
          s_axi_bresp <= `OPC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `OPC_RESP_SLVERR;
        end
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `OPC_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `OPC_RESP_OKAY;
      if (s_axi_araddr == `OPC_ADDR_PLL) begin
        s_axi_rdata <= pll_word;
      end else if (s_axi_araddr == `OPC_ADDR_STAT) begin
        s_axi_rdata <= {ratio_q, 12'h0, int_osc_select, strap_q, state_q == ST_RUN};
      end else if (s_axi_araddr == `OPC_ADDR_REF) begin
        s_axi_rdata <= ref_word;
      end else if (s_axi_araddr == `OPC_ADDR_TIMER) begin
        s_axi_rdata <= timer_q;
      end else if (s_axi_araddr == `OPC_ADDR_CLKBLK) begin
        s_axi_rdata <= cb_word;
      end else if (s_axi_araddr == `OPC_ADDR_TILE) begin
        s_axi_rdata <= tile_khz(osc_khz, pll_multiplier, pll_input_divider,
                                post_divider);
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `OPC_RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slow oscillator, reference tick and timer.

  reg [11:0] slow_cnt_q;
  reg [7:0]  ref_acc_q;
  wire [8:0] ref_sum = {1'b0, ref_acc_q} + {1'b0, ref_mhz_q};

  // The slow tick runs whatever the boot state, so the counter never stalls.
  always @(posedge aclk) begin
    if (!aresetn) begin
      slow_cnt_q <= 12'h0;
      slow_tick  <= 1'b0;
    end else begin
      slow_tick  <= (slow_cnt_q == SLOW_LAST);
      slow_cnt_q <= (slow_cnt_q == SLOW_LAST) ? 12'h0 : slow_cnt_q + 12'h1;
    end
  end

  // Fractional accumulator: for ref_mhz_q up to 125 the tick rate averages ref_mhz_q MHz at 125 MHz.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_acc_q <= 8'h0;
      ref_tick  <= 1'b0;
      timer_q   <= 32'h0;
    end else begin
      if (ref_sum >= {1'b0, CLK_MHZ}) begin
        ref_acc_q <= ref_sum[7:0] - CLK_MHZ;
        ref_tick  <= 1'b1;
      end else begin
        ref_acc_q <= ref_sum[7:0];
        ref_tick  <= 1'b0;
      end
      if (ref_tick) begin
        timer_q <= timer_q + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock block 0.

  reg [7:0] cb_cnt_q;
  reg       cb_div_clk_q;
  wire      ext_rise = ext_sync_q[1] && !ext_sync_q[2];
  wire      div_rise = ref_tick && (cb_cnt_q == cb_div_q) && !cb_div_clk_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cb_cnt_q     <= 8'h0;
      cb_div_clk_q <= 1'b0;
      cb_pin_out   <= 1'b0;
      cb_tick      <= 1'b0;
    end else begin
      if (ref_tick) begin
        if (cb_cnt_q == cb_div_q) begin
          cb_cnt_q     <= 8'h0;
          cb_div_clk_q <= !cb_div_clk_q;
        end else begin
          cb_cnt_q <= cb_cnt_q + 8'h1;
        end
      end
      cb_pin_out <= cb_src_ext_q ? ext_sync_q[1] : cb_div_clk_q;
      cb_tick    <= cb_src_ext_q ? ext_rise : div_rise;
    end
  end

endmodule
`default_nettype wire

// [opc_clock_monitor.sv]
// Port-level assertions for the clock control block, bound into it.
`timescale 1ns/1ns
`default_nettype none
module opc_clock_monitor (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus handshakes.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Clock and boot outputs.
  input wire logic        int_osc_select,
  input wire logic        analog_clk_int_osc,
  input wire logic        pull_enable,
  input wire logic        boot_start,
  input wire logic        slow_tick
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // The first gap after reset has an unknown phase, so it is not judged.
  logic [12:0] gap_q;
  logic        seen_q;
  always @(posedge aclk) begin
    if (!aresetn || slow_tick) begin
      gap_q  <= 13'h0;
      seen_q <= aresetn;
    end else begin
      gap_q <= gap_q + 13'h1;
    end
  end
  sequence wr_take_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  slow_gap_a: assert property (slow_tick && seen_q |-> gap_q == 13'd3999)
    else $error("slow tick spacing wrong");
  slow_miss_a: assert property (seen_q |-> gap_q < 13'd4000)
    else $error("slow tick missing");
  wr_resp_a: assert property (wr_take_s |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (rd_take_s |=> s_axi_rvalid)
    else $error("read response late");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  osc_match_a: assert property (analog_clk_int_osc == int_osc_select)
    else $error("analog clock source differs");
  osc_hold_a: assert property (pull_enable |-> $stable(int_osc_select))
    else $error("oscillator source changed after boot");
  boot_pulse_a: assert property (boot_start |=> !boot_start && pull_enable)
    else $error("boot pulse wrong");
  pull_hold_a: assert property ($rose(pull_enable) |=> pull_enable [*4])
    else $error("pull enable dropped");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind opc_clock_ctrl opc_clock_monitor u_mon (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .int_osc_select, .analog_clk_int_osc,
  .pull_enable, .boot_start, .slow_tick
);
`default_nettype wire

// [opc_board_model.sv]
// Board model: oscillator select pin, PLL straps and an external clock pin.
`timescale 1ns/1ns
`default_nettype none
module opc_board_model #(
  parameter int EXT_HALF = 5
) (
  // Clock and reset seen by the board.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Levels asked for by the bench.
  input  wire logic [1:0] strap_req,
  input  wire logic       src_req,
  // Pins into the device.
  output var  logic       clk_source_select_n,
  output var  logic       pll_strap_lo,
  output var  logic       pll_strap_hi,
  output var  logic       cb_ext_clk_pin
);
  int cnt;
  initial begin
    {pll_strap_hi, pll_strap_lo, clk_source_select_n, cb_ext_clk_pin} = 4'h0;
    cnt = 0;
  end
  always @(posedge aclk) begin
    // Straps move only while reset is held, so they are still long after the capture edge.
    if (!aresetn) begin
      {pll_strap_hi, pll_strap_lo} <= strap_req;
      clk_source_select_n <= src_req;
    end
    // The external clock runs free, like a real oscillator on the pin.
    cnt <= (cnt == EXT_HALF - 1) ? 0 : cnt + 1;
    if (cnt == EXT_HALF - 1) cb_ext_clk_pin <= ~cb_ext_clk_pin;
  end
endmodule
`default_nettype wire

// [tb_oscillator_pll_clock_control.sv]
// Self-checking bench for the clock control block.
`timescale 1ns/1ns
`default_nettype none
`include "opc_regs.vh"
module tb_oscillator_pll_clock_control;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, srcn, lo, hi, ext;
  logic [1:0]  bresp, rresp, strap_req = 2'h0;
  logic        src_req = 1'b0;
  logic [2:0]  post_divider;
  logic [11:0] pll_multiplier;
  logic [5:0]  pll_input_divider;
  logic        int_osc, ana_osc, pll_en, pull_en, boot, slow, ref_tick, cb_out, cb_oe, cb_tick;
  logic [7:0]  port_sel;
  int          n_mismatch = 0, cmp_count = 0;
  logic [31:0] seed = 32'h25ef;
  always #4 aclk = ~aclk;
  opc_clock_ctrl #(.BOOT_WAIT(20)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .clk_source_select_n(srcn), .pll_strap_lo(lo), .pll_strap_hi(hi),
    .post_divider(post_divider), .pll_multiplier(pll_multiplier),
    .pll_input_divider(pll_input_divider), .int_osc_select(int_osc),
    .analog_clk_int_osc(ana_osc), .pll_clk_enable(pll_en), .pull_enable(pull_en),
    .boot_start(boot), .slow_tick(slow), .ref_tick(ref_tick), .cb_ext_clk_pin(ext),
    .cb_pin_out(cb_out), .cb_pin_oe(cb_oe), .cb_tick(cb_tick), .port_clkblk_sel(port_sel));
  opc_board_model brd (.aclk(aclk), .aresetn(aresetn), .strap_req(strap_req), .src_req(src_req),
    .clk_source_select_n(srcn), .pll_strap_lo(lo), .pll_strap_hi(hi), .cb_ext_clk_pin(ext));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic int tile_khz(input int osc, input int f, input int r, input int od);
    return osc * (f + 1) / (2 * (r + 1) * (od + 1));
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Only the watchdog ends a wait, so a missing response fails the run.
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
    chk(r, `OPC_RESP_OKAY);
  endtask
  task automatic rst(input logic [1:0] s, input logic src);
    @(posedge aclk);
    aresetn <= 1'b0;
    strap_req <= s;
    src_req <= src;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic count(input int n, output int rt, output int ct, output int pt);
    logic last;
    rt = 0;
    ct = 0;
    pt = 0;
    last = cb_out;
    repeat (n) begin
      @(posedge aclk);
      rt += ref_tick;
      ct += cb_tick;
      pt += (cb_out && !last);
      last = cb_out;
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int od_t[4] = '{1, 2, 2, 2};
    int f_t[4] = '{122, 23, 49, 119};
    int rat_t[4] = '{3075, 400, 833, 2000};
    int rt, ct, pt;
    logic [31:0] d, t1;
    logic [1:0]  r, s2;
    logic [2:0]  od;
    logic [11:0] f;
    logic [5:0]  rr;
    for (int s = 0; s < 4; s++) begin
      s2 = s[1:0];
      rst(s2, s2[0]);
      repeat (3) @(posedge aclk);
      chk(pull_en, 1'b0);
      repeat (37) @(posedge aclk);
      chk({pull_en, pll_en}, 2'b11);
      chk({post_divider, pll_multiplier, pll_input_divider}, {od_t[s][2:0], f_t[s][11:0], 6'h0});
      chk({int_osc, ana_osc}, {2{s2[0]}});
      rdc(`OPC_ADDR_PLL, od_t[s] << 24 | f_t[s] << 8);
      rdc(`OPC_ADDR_STAT, rat_t[s] << 16 | s2[0] << 3 | s2 << 1 | 1);
      rdc(`OPC_ADDR_TILE, tile_khz(s2[0] ? 20000 : 12000, f_t[s], 0, od_t[s]));
      rdc(`OPC_ADDR_CLKBLK, 32'h0);
      chk(port_sel, 8'h0);
      $display("test strap %0d done", s);
    end
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      f = (i == 0) ? 12'd51 : 12'd25 + 12'(seed[15:0] % 105);
      rr = (i == 0) ? 6'd1 : 6'd0;
      od = seed[26:24];
      wr(`OPC_ADDR_PLL, {5'h0, od, 4'h0, f, 2'h0, rr}, `OPC_RESP_OKAY);
      rdc(`OPC_ADDR_PLL, {5'h0, od, 4'h0, f, 2'h0, rr});
      chk({post_divider, pll_multiplier, pll_input_divider}, {od, f, rr});
      rdc(`OPC_ADDR_TILE, tile_khz(20000, f, rr, od));
    end
    wr(`OPC_ADDR_STAT, 32'h0, `OPC_RESP_OKAY);
    rdc(`OPC_ADDR_STAT, rat_t[3] << 16 | 32'hf);
    wr(8'h20, seed, `OPC_RESP_SLVERR);
    rd(8'h20, d, r);
    chk(r, `OPC_RESP_SLVERR);
    chk(d, 32'h0);
    $display("test pll reprogram done");
    rdc(`OPC_ADDR_REF, 32'h64);
    rd(`OPC_ADDR_TIMER, t1, r);
    chk(r, `OPC_RESP_OKAY);
    count(125, rt, ct, pt);
    chk(rt, 100);
    rd(`OPC_ADDR_TIMER, d, r);
    chk(d - t1 >= rt && d - t1 <= rt + 4, 1'b1);
    wr(`OPC_ADDR_REF, 32'h32, `OPC_RESP_OKAY);
    count(125, rt, ct, pt);
    chk(rt, 50);
    wr(`OPC_ADDR_REF, 32'h64, `OPC_RESP_OKAY);
    $display("test reference done");
    wr(`OPC_ADDR_CLKBLK, 32'h0003_0102, `OPC_RESP_OKAY);
    chk({cb_oe, port_sel}, {1'b1, 8'h03});
    count(125, rt, ct, pt);
    chk(ct >= 24 && ct <= 26, 1'b1);
    chk(pt >= 24 && pt <= 26, 1'b1);
    wr(`OPC_ADDR_CLKBLK, 32'h0000_0101, `OPC_RESP_OKAY);
    count(125, rt, ct, pt);
    chk({cb_oe, ct >= 11 && ct <= 13}, 2'b01);
    chk(pt >= 11 && pt <= 13, 1'b1);
    $display("test clock block done");
    // Long idle so at least two slow ticks, and one whole gap between them, are seen by the monitor.
    repeat (8100) @(posedge aclk);
    $display("test slow tick done");
    summarize();
  end
  initial begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
